// *** logic/bms_boot_steer.sv ***
// Boot mode latch and host mirror window steering.
// Assumes boot-select pins are synchronous to clk_sys_i and stable around reset release.
// Assumes the host and the instruction RAM share the one system clock.
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - Pins 00 ext memory, 01 serial flash, 10 ext host, 11 IRAM debug.
// - External memory boot disables the host interface entirely.
// - Serial flash boot: host window accesses hit reserved space and are refused.
// - External host boot: boot from IRAM, host window steered to IRAM.
// - IRAM boot: host window steered to IRAM, debug use only.
// - A 768 Kbyte mirror window whose target depends on boot mode.
// - External memory boot fetches from memory on chip select zero.
module bms_boot_steer (
    // Clock, reset and enable
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    // Boot-select pins
    input wire logic boot_select_high_i,
    input wire logic boot_select_low_i,
    // Host mirror window request
    input wire bms_pkg::bms_req_t host_req_i,
    output logic host_ready_o,
    output logic host_err_o,
    output logic [bms_pkg::BMS_DATA_W-1:0] host_rdata_o,
    // Instruction RAM port
    output logic iram_req_o,
    output logic iram_write_o,
    output logic [bms_pkg::BMS_ADDR_W-1:0] iram_addr_o,
    output logic [bms_pkg::BMS_DATA_W-1:0] iram_wdata_o,
    input wire logic [bms_pkg::BMS_DATA_W-1:0] iram_rdata_i,
    // Boot control
    output bms_pkg::bms_boot_src_t boot_src_o,
    output logic ext_bus_chip_select_zero_boot_o,
    output bms_pkg::bms_status_t status_o,
    output logic mode_valid_o
);
    import bms_pkg::*;

    // ------------------------------------------------------------
    // Clock enable
    // ------------------------------------------------------------
    // Every register below advances only on an enabled edge, so a low
    // enable freezes the block, a capture still to come included.
    logic step_w;

    assign step_w = clk_en_i;

    // ------------------------------------------------------------
    // Mode capture
    // ------------------------------------------------------------
    // The first enabled edge after reset release captures the pins; later
    // pin changes are ignored until the next reset.
    bms_mode_t mode_r;
    bms_mode_t mode_nxt;
    logic latched_r;
    logic latched_nxt;
    logic capture_w;
    logic [1:0] pins_w;
    bms_mode_t mode_dec_w;

    assign pins_w = {boot_select_high_i, boot_select_low_i};
    assign mode_dec_w = (pins_w == BMS_SEL_EXT_MEM) ? BMS_MODE_EXT_MEM :
                        (pins_w == BMS_SEL_SERIAL_FLASH) ? BMS_MODE_SERIAL_FLASH :
                        (pins_w == BMS_SEL_EXT_HOST) ? BMS_MODE_EXT_HOST :
                        BMS_MODE_IRAM_DEBUG;
    assign capture_w = step_w && !latched_r;
    assign mode_nxt = capture_w ? mode_dec_w : mode_r;
    assign latched_nxt = latched_r || capture_w;

    // ------------------------------------------------------------
    // Mode register
    // ------------------------------------------------------------
    // The captured flag, with any mode but external memory, opens the host side; it never falls before the next reset.
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mode_r <= BMS_MODE_EXT_MEM;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            latched_r <= '0;
        end else begin
            latched_r <= latched_nxt;
        end
    end

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    // Every flag waits for the capture, so the host side stays shut
    // through reset and until the pins have been taken.
    logic is_ext_mem_w;
    logic is_flash_w;
    logic is_host_w;
    logic is_debug_w;
    logic host_en_w;
    logic to_iram_w;
    logic in_window_w;
    logic take_w;

    assign is_ext_mem_w = latched_r && (mode_r == BMS_MODE_EXT_MEM);
    assign is_flash_w = latched_r && (mode_r == BMS_MODE_SERIAL_FLASH);
    assign is_host_w = latched_r && (mode_r == BMS_MODE_EXT_HOST);
    assign is_debug_w = latched_r && (mode_r == BMS_MODE_IRAM_DEBUG);
    assign host_en_w = is_flash_w || is_host_w || is_debug_w;
    assign to_iram_w = is_host_w || is_debug_w;
    // Addresses at or above the window top are refused rather than wrapped,
    // so the host never reaches one RAM word through two addresses.
    assign in_window_w = host_req_i.addr < BMS_WINDOW_BYTES;
    // Requests seen while frozen are neither granted nor refused; the host
    // keeps them up until an answer arrives.
    assign take_w = step_w && host_req_i.valid && host_en_w;

    // ------------------------------------------------------------
    // Boot control outputs
    // ------------------------------------------------------------
    // The reset value of the mode register points the CPU at chip select
    // zero until the pins have been captured.
    assign boot_src_o = (mode_r == BMS_MODE_SERIAL_FLASH) ? BMS_BOOT_SERIAL_FLASH :
                        (mode_r == BMS_MODE_EXT_HOST) ? BMS_BOOT_IRAM :
                        (mode_r == BMS_MODE_IRAM_DEBUG) ? BMS_BOOT_IRAM :
                        BMS_BOOT_CS0_MEM;
    assign ext_bus_chip_select_zero_boot_o = is_ext_mem_w;
    assign mode_valid_o = latched_r;
    // Status repeats the decode for whoever reports the boot path.
    assign status_o = '{
        boot_cs0: is_ext_mem_w,
        boot_flash: is_flash_w,
        boot_iram: to_iram_w,
        host_if_en: host_en_w,
        debug_only: is_debug_w
    };

    // ------------------------------------------------------------
    // Host access steering
    // ------------------------------------------------------------
    // Accepted requests go to IRAM combinationally; ready or error comes one
    // enabled cycle later, and read data from IRAM one enabled cycle after that.
    logic grant_w;
    logic refuse_w;

    // Serial flash boot refuses every window access, because the window
    // maps onto reserved space in that mode.
    assign grant_w = take_w && to_iram_w && in_window_w;
    assign refuse_w = take_w && !grant_w;

    // ------------------------------------------------------------
    // IRAM port
    // ------------------------------------------------------------
    assign iram_req_o = grant_w;
    assign iram_write_o = grant_w && host_req_i.write;
    assign iram_addr_o = grant_w ? host_req_i.addr : '0;
    assign iram_wdata_o = grant_w ? host_req_i.wdata : '0;

    // ------------------------------------------------------------
    // Answer registers
    // ------------------------------------------------------------
    // A frozen cycle holds every answer as it stands. Read data is taken
    // one enabled edge after the grant, when the RAM has answered.
    logic ready_r;
    logic ready_nxt;
    logic err_r;
    logic err_nxt;
    logic rd_r;
    logic rd_nxt;
    logic [BMS_DATA_W-1:0] rdata_r;
    logic [BMS_DATA_W-1:0] rdata_nxt;

    assign ready_nxt = step_w ? (grant_w || refuse_w) : ready_r;
    assign err_nxt = step_w ? refuse_w : err_r;
    assign rd_nxt = step_w ? (grant_w && !host_req_i.write) : rd_r;
    assign rdata_nxt = !step_w ? rdata_r : (rd_r ? iram_rdata_i : '0);

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ready_r <= '0;
        end else begin
            ready_r <= ready_nxt;
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            err_r <= '0;
        end else begin
            err_r <= err_nxt;
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rd_r <= '0;
        end else begin
            rd_r <= rd_nxt;
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // Host answer outputs
    // ------------------------------------------------------------
    // The answer flags come straight from flip-flops, so the host sees clean pulses.
    assign host_ready_o = ready_r;
    assign host_err_o = err_r;
    assign host_rdata_o = rdata_r;

endmodule

`default_nettype wire

// *** shared/bms_pkg.sv ***
// Package for the boot mode access steering block: modes, targets, window layout.
// Assumes a single 25 MHz system clock domain and no software-visible registers.
package bms_pkg;

    // ------------------------------------------------------------
    // Boot modes and host access targets
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        BMS_MODE_EXT_MEM,
        BMS_MODE_SERIAL_FLASH,
        BMS_MODE_EXT_HOST,
        BMS_MODE_IRAM_DEBUG
    } bms_mode_t;

    localparam logic [1:0] BMS_SEL_EXT_MEM = 2'h0;
    localparam logic [1:0] BMS_SEL_SERIAL_FLASH = 2'h1;
    localparam logic [1:0] BMS_SEL_EXT_HOST = 2'h2;
    localparam logic [1:0] BMS_SEL_IRAM_DEBUG = 2'h3;

    typedef enum logic [1:0] {
        BMS_BOOT_CS0_MEM,
        BMS_BOOT_SERIAL_FLASH,
        BMS_BOOT_IRAM
    } bms_boot_src_t;

    // ------------------------------------------------------------
    // Mirror window layout
    // ------------------------------------------------------------
    localparam int BMS_ADDR_W = 20;
    localparam int BMS_DATA_W = 32;
    localparam int BMS_WINDOW_KBYTES = 768;
    localparam logic [BMS_ADDR_W-1:0] BMS_WINDOW_BYTES = 20'hc0000;

    typedef struct packed {
        logic valid;
        logic write;
        logic [BMS_ADDR_W-1:0] addr;
        logic [BMS_DATA_W-1:0] wdata;
    } bms_req_t;

    typedef struct packed {
        logic boot_cs0;
        logic boot_flash;
        logic boot_iram;
        logic host_if_en;
        logic debug_only;
    } bms_status_t;

endpackage

// *** sim/bms_boot_steer_sva.sv ***
// Port assertions for the boot steering block.
// Assumes it is bound to bms_boot_steer.
`timescale 1ns/1ns
`default_nettype none
module bms_sva (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    input wire logic boot_select_high_i,
    input wire logic boot_select_low_i,
    input wire bms_pkg::bms_req_t host_req_i,
    input wire logic host_ready_o,
    input wire logic host_err_o,
    input wire logic iram_req_o,
    input wire bms_pkg::bms_boot_src_t boot_src_o,
    input wire logic ext_bus_chip_select_zero_boot_o,
    input wire logic mode_valid_o
);
    import bms_pkg::*;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    wire logic [1:0] sel = {boot_select_high_i, boot_select_low_i};
    wire logic cs0 = ext_bus_chip_select_zero_boot_o;
    wire logic take = clk_en_i && host_req_i.valid && mode_valid_o && !cs0;
    pin_decode_a: assert property ($rose(mode_valid_o) |->
        boot_src_o == ($past(sel) == 2'h0 ? BMS_BOOT_CS0_MEM :
        $past(sel) == 2'h1 ? BMS_BOOT_SERIAL_FLASH : BMS_BOOT_IRAM)) else $error("decode");
    mode_hold_a: assert property (mode_valid_o |=> mode_valid_o && $stable(boot_src_o))
        else $error("mode moved");
    cs0_flag_a: assert property (mode_valid_o |-> cs0 == (boot_src_o == BMS_BOOT_CS0_MEM))
        else $error("cs0 flag");
    host_off_a: assert property (cs0 |-> !host_ready_o && !iram_req_o)
        else $error("host not off");
    flash_refuse_a: assert property (boot_src_o == BMS_BOOT_SERIAL_FLASH |-> !iram_req_o &&
        host_err_o == host_ready_o) else $error("flash access");
    take_ready_a: assert property (take |=> host_ready_o)
        else $error("no ready");
    iram_grant_a: assert property (iram_req_o |-> boot_src_o == BMS_BOOT_IRAM &&
        host_req_i.valid && host_req_i.addr < BMS_WINDOW_BYTES) else $error("bad grant");
    window_range_a: assert property (take && host_req_i.addr >= BMS_WINDOW_BYTES |=>
        host_err_o) else $error("outside window");
endmodule
bind bms_boot_steer bms_sva u_sva (.clk_sys_i, .resetn_i, .clk_en_i, .boot_select_high_i,
    .boot_select_low_i, .host_req_i, .host_ready_o, .host_err_o, .iram_req_o, .boot_src_o,
    .ext_bus_chip_select_zero_boot_o, .mode_valid_o);
`default_nettype wire

// *** sim/bms_iram_model.sv ***
// Instruction RAM model with one cycle of read latency.
// Assumes a 16-word store is enough for the bench.
`timescale 1ns/1ns
`default_nettype none
module bms_iram_model (
    input wire logic clk_i,
    input wire logic req_i,
    input wire logic write_i,
    input wire logic [19:0] addr_i,
    input wire logic [31:0] wdata_i,
    output logic [31:0] rdata_o
);
    logic [31:0] mem [16];
    // Each idle cycle inverts the previous output, so a held word flips between itself and its inverse.
    always @(posedge clk_i) begin
        if (req_i && write_i) mem[addr_i[5:2]] <= wdata_i;
        rdata_o <= req_i ? mem[addr_i[5:2]] : ~rdata_o;
    end
endmodule
`default_nettype wire

// *** sim/test_boot_mode_access_steering.sv ***
// Bench booting the steering block in each mode and driving window traffic.
// Assumes bms_iram_model as the RAM behind the window.
`timescale 1ns/1ns
`default_nettype none
module test_boot_mode_access_steering;
    import bms_pkg::*;
    logic clk_sys_i = 1'b0;
    logic resetn_i, clk_en_i, boot_select_high_i, boot_select_low_i, host_ready_o, host_err_o;
    logic iram_req_o, iram_write_o, mode_valid_o, cs0;
    logic [19:0] iram_addr_o;
    logic [31:0] host_rdata_o, iram_wdata_o, iram_rdata_i;
    bms_req_t host_req_i;
    bms_boot_src_t boot_src_o;
    bms_status_t status_o;
    int errors = 0;
    int total_checks = 0;
    always #20 clk_sys_i = ~clk_sys_i;
    bms_boot_steer dut (.clk_sys_i, .resetn_i, .clk_en_i, .boot_select_high_i,
        .boot_select_low_i, .host_req_i, .host_ready_o, .host_err_o, .host_rdata_o, .iram_req_o,
        .iram_write_o, .iram_addr_o, .iram_wdata_o, .iram_rdata_i, .boot_src_o,
        .ext_bus_chip_select_zero_boot_o(cs0), .status_o, .mode_valid_o);
    bms_iram_model u_iram (.clk_i(clk_sys_i), .req_i(iram_req_o), .write_i(iram_write_o),
        .addr_i(iram_addr_o), .wdata_i(iram_wdata_o), .rdata_o(iram_rdata_i));
    task chk(input string n, input logic [31:0] s, e);
        total_checks++;
        if (s !== e) begin
            errors++;
            $display("[FAIL] %s exp %h got %h", n, e, s);
        end
    endtask
    task results;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task boot(input logic [1:0] s, input bms_boot_src_t src);
        int i;
        {boot_select_high_i, boot_select_low_i} = s;
        resetn_i = 1'b0;
        repeat (6) @(negedge clk_sys_i);
        clk_en_i = 1'b0;
        resetn_i = 1'b1;
        repeat (2) @(negedge clk_sys_i);
        chk("frozen", mode_valid_o, 1'b0);
        clk_en_i = 1'b1;
        for (i = 0; i < 8 && mode_valid_o !== 1'b1; i++) @(negedge clk_sys_i);
        if (i == 8) begin
            errors++;
            results();
        end
        @(negedge clk_sys_i);
        chk("src", boot_src_o, src);
        chk("cs0", cs0, s == 2'h0);
        chk("status", status_o, {s == 2'h0, s == 2'h1, s[1], s != 2'h0, s == 2'h3});
    endtask
    task acc(input logic w, input logic [19:0] a, input logic [31:0] d, input logic r, e);
        host_req_i = {1'b1, w, a, d};
        @(negedge clk_sys_i);
        host_req_i.valid = 1'b0;
        chk("ready", host_ready_o, r);
        chk("err", host_err_o, e);
        @(negedge clk_sys_i);
        if (!w) chk("rdata", host_rdata_o, (r && !e) ? d : 32'h0);
    endtask
    task t_ext;
        boot(2'h0, BMS_BOOT_CS0_MEM);
        acc(1'b0, 20'h0, 32'h0, 1'b0, 1'b0);
        $display("ext memory test end");
    endtask
    task t_flash;
        boot(2'h1, BMS_BOOT_SERIAL_FLASH);
        acc(1'b0, 20'h100, 32'h0, 1'b1, 1'b1);
        $display("flash test end");
    endtask
    task t_host;
        boot(2'h2, BMS_BOOT_IRAM);
        acc(1'b1, 20'h0, 32'hcafe0001, 1'b1, 1'b0);
        acc(1'b1, 20'hbfffc, 32'h5a5a0002, 1'b1, 1'b0);
        acc(1'b0, 20'h0, 32'hcafe0001, 1'b1, 1'b0);
        acc(1'b0, 20'hbfffc, 32'h5a5a0002, 1'b1, 1'b0);
        acc(1'b0, 20'hc0000, 32'h0, 1'b1, 1'b1);
        $display("host test end");
    endtask
    task t_dbg;
        boot(2'h3, BMS_BOOT_IRAM);
        chk("debug", status_o.debug_only, 1'b1);
        {boot_select_high_i, boot_select_low_i} = 2'h0;
        acc(1'b1, 20'h40, 32'h1234abcd, 1'b1, 1'b0);
        acc(1'b0, 20'h40, 32'h1234abcd, 1'b1, 1'b0);
        chk("held", boot_src_o, BMS_BOOT_IRAM);
        $display("debug test end");
    endtask
    initial begin
        clk_en_i = 1'b1;
        host_req_i = '0;
        t_ext();
        t_flash();
        t_host();
        t_dbg();
        results();
    end
endmodule
`default_nettype wire
